// file: design/uart_core.sv
`timescale 1ns/100ps
`default_nettype none
module uart_core
	import uart_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int AW = 4
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// host bus
	input wire bus_req_t bus,
	output logic [7:0] data_out,
	output logic data_oe_n,
	// serial and modem pins
	input wire pins_t pins,
	output logic serial_output,
	output logic rts_n,
	output logic dtr_n,
	output logic user_output_one_n,
	output logic user_output_two_n,
	// requests
	output logic host_interrupt_out,
	output logic transmit_dma_request_n,
	output logic receive_dma_request_n
);
	logic [7:0] lcr_r, ier_r, scr_r;
	logic [4:0] mcr_r;
	logic [15:0] div_r;
	logic fifo_en_r, dma_sel_r;
	logic [1:0] trig_sel_r;
	pins_t s1_r, s2_r, s3_r, filt_r;
	logic [15:0] bcnt_r;
	logic tick;
	logic [7:0] tx_mem [DEPTH];
	logic [8:0] rx_mem [DEPTH];
	logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	logic [AW:0] tx_cnt_r, rx_cnt_r, cap, trig;
	tx_state_t tx_st_r;
	rx_state_t rx_st_r;
	logic [4:0] twait_r;
	logic [3:0] tph_r, rph_r, tbit_r, rbit_r, nbits;
	logic [8:0] tsh_r;
	logic [7:0] rsh_r;
	logic temt_r, holding_empty_flag_ip_r, oe_r, fe_r, to_ip_r;
	logic [10:0] to_cnt_r;
	logic [3:0] dlt_r, iid;
	logic [3:0] mprev_r;
	logic divisor_access_select, rd_q, wr_q, tx_push, tx_pop, rx_push, rx_pop, fifo_rst_tx, fifo_rst_rx;
	logic rx_fe, ls_pend, rda_pend, mode1, temt_evt;

	// register decode
	assign divisor_access_select = lcr_r[DIVISOR_ACCESS_SELECT_BIT];
	assign rd_q = bus.cs & bus.rd;
	assign wr_q = bus.cs & bus.wr;
	assign nbits = 4'h5 + {2'b00, lcr_r[1:0]};
	assign cap = fifo_en_r ? (AW+1)'(DEPTH) : (AW+1)'(1);
	assign mode1 = fifo_en_r & dma_sel_r;
	assign tx_push = wr_q && bus.addr == ADDR_DATA && !divisor_access_select && tx_cnt_r < cap;
	assign rx_pop = rd_q && bus.addr == ADDR_DATA && !divisor_access_select && rx_cnt_r != '0;
	assign fifo_rst_rx = wr_q && bus.addr == ADDR_IIR && (bus.wdata[FCR_RXRST_BIT] || bus.wdata[FCR_EN_BIT] != fifo_en_r);
	assign fifo_rst_tx = wr_q && bus.addr == ADDR_IIR && (bus.wdata[FCR_TXRST_BIT] || bus.wdata[FCR_EN_BIT] != fifo_en_r);

	always_comb
	begin
		case (trig_sel_r)
			2'b00: trig = (AW+1)'(TRIG_00);
			2'b01: trig = (AW+1)'(TRIG_01);
			2'b10: trig = (AW+1)'(TRIG_10);
			default: trig = (AW+1)'(TRIG_11);
		endcase
	end

	// software registers
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			lcr_r <= REG_RESET;
			ier_r <= REG_RESET;
			mcr_r <= REG_RESET[4:0];
			scr_r <= REG_RESET;
			div_r <= DIV_RESET;
			fifo_en_r <= 1'b0;
			dma_sel_r <= 1'b0;
			trig_sel_r <= 2'b00;
		end
		else if (wr_q)
		begin
			case (bus.addr)
				ADDR_DATA:
					if (divisor_access_select)
						div_r[7:0] <= bus.wdata;
				ADDR_IER:
					if (divisor_access_select)
						div_r[15:8] <= bus.wdata;
					else
						ier_r <= {4'h0, bus.wdata[3:0]};
				ADDR_IIR:
				begin
					fifo_en_r <= bus.wdata[FCR_EN_BIT];
					dma_sel_r <= bus.wdata[FCR_DMA_BIT];
					trig_sel_r <= bus.wdata[7:6];
				end
				ADDR_LCR: lcr_r <= bus.wdata;
				ADDR_MCR: mcr_r <= bus.wdata[4:0];
				ADDR_SCR: scr_r <= bus.wdata;
				default: ;
			endcase
		end
	end

	assign dtr_n = ~mcr_r[0];
	assign rts_n = ~mcr_r[1];
	assign user_output_one_n = ~mcr_r[2];
	assign user_output_two_n = ~mcr_r[3];

	// pin synchroniser, a change counts when stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s1_r <= PIN_IDLE;
			s2_r <= PIN_IDLE;
			s3_r <= PIN_IDLE;
			filt_r <= PIN_IDLE;
		end
		else
		begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
		end
	end

	// baud tick generator
	assign tick = div_r != '0 && bcnt_r >= div_r - 16'h0001;
	always_ff @(posedge mclk)
	begin
		if (!rst_n || tick || div_r == '0)
			bcnt_r <= '0;
		else
			bcnt_r <= bcnt_r + 16'h0001;
	end

	// transmit fifo
	always_ff @(posedge mclk)
	begin
		if (tx_push)
			tx_mem[tx_wp_r] <= bus.wdata;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n || fifo_rst_tx)
		begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_cnt_r <= '0;
		end
		else
		begin
			if (tx_push)
				tx_wp_r <= tx_wp_r + 1'b1;
			if (tx_pop)
				tx_rp_r <= tx_rp_r + 1'b1;
			tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
		end
	end

	// transmitter
	assign tx_pop = tx_st_r == TX_WAIT && tick && twait_r == TX_START_TICKS - 5'h01 && tx_cnt_r != '0;
	assign temt_evt = tx_st_r == TX_STOP && tick && tph_r == TEMT_TICKS - 4'h1 && tx_cnt_r == '0;
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tx_st_r <= TX_IDLE;
			serial_output <= 1'b1;
			twait_r <= '0;
			tph_r <= '0;
			tbit_r <= '0;
			tsh_r <= '1;
		end
		else
		begin
			case (tx_st_r)
				TX_IDLE:
					if (tx_cnt_r != '0)
					begin
						tx_st_r <= TX_WAIT;
						twait_r <= '0;
					end
				TX_WAIT:
					if (tx_cnt_r == '0)
						tx_st_r <= TX_IDLE;
					else if (tx_pop)
					begin
						tx_st_r <= TX_SHIFT;
						serial_output <= 1'b0;
						tsh_r <= {tx_mem[tx_rp_r], 1'b0};
						tph_r <= '0;
						tbit_r <= '0;
					end
					else if (tick)
						twait_r <= twait_r + 5'h01;
				TX_SHIFT:
					if (tick)
					begin
						tph_r <= tph_r + 4'h1;
						if (tph_r == TICKS_PER_BIT)
						begin
							if (tbit_r == nbits)
							begin
								tx_st_r <= TX_STOP;
								serial_output <= 1'b1;
							end
							else
							begin
								serial_output <= tsh_r[1];
								tsh_r <= {1'b1, tsh_r[8:1]};
								tbit_r <= tbit_r + 4'h1;
							end
						end
					end
				TX_STOP:
					if (tick)
					begin
						tph_r <= tph_r + 4'h1;
						if (tph_r == TICKS_PER_BIT)
						begin
							tx_st_r <= tx_cnt_r != '0 ? TX_WAIT : TX_IDLE;
							twait_r <= TX_START_TICKS - 5'h01;
						end
					end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// transmitter empty and holding-empty interrupt
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			temt_r <= 1'b1;
		else if (temt_evt)
			temt_r <= 1'b1;
		else if (tx_push)
			temt_r <= 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			holding_empty_flag_ip_r <= 1'b0;
		else if ((tx_pop && tx_cnt_r == (AW+1)'(1)) || temt_evt)
			holding_empty_flag_ip_r <= 1'b1;
		else if (tx_push || (rd_q && bus.addr == ADDR_IIR && iid == IID_HOLDING_EMPTY_FLAG))
			holding_empty_flag_ip_r <= 1'b0;
	end

	// receiver
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rx_st_r <= RX_IDLE;
			rph_r <= '0;
			rbit_r <= '0;
			rsh_r <= '0;
		end
		else
		begin
			case (rx_st_r)
				RX_IDLE:
					if (!filt_r.sin)
					begin
						rx_st_r <= RX_START;
						rph_r <= '0;
					end
				RX_START:
					if (tick)
					begin
						rph_r <= rph_r + 4'h1;
						if (rph_r == HALF_BIT_TICKS)
						begin
							rx_st_r <= filt_r.sin ? RX_IDLE : RX_DATA;
							rph_r <= '0;
							rbit_r <= '0;
						end
					end
				RX_DATA:
					if (tick)
					begin
						rph_r <= rph_r + 4'h1;
						if (rph_r == TICKS_PER_BIT)
						begin
							rsh_r <= {filt_r.sin, rsh_r[7:1]};
							rbit_r <= rbit_r + 4'h1;
							if (rbit_r == nbits - 4'h1)
								rx_st_r <= RX_STOP;
						end
					end
				RX_STOP:
					if (tick)
					begin
						rph_r <= rph_r + 4'h1;
						if (rph_r == TICKS_PER_BIT)
							rx_st_r <= RX_IDLE;
					end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end
	assign rx_push = rx_st_r == RX_STOP && tick && rph_r == TICKS_PER_BIT;
	assign rx_fe = ~filt_r.sin;

	// receive fifo
	always_ff @(posedge mclk)
	begin
		if (rx_push && rx_cnt_r < cap)
			rx_mem[rx_wp_r] <= {rx_fe, rsh_r >> (4'h8 - nbits)};
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n || fifo_rst_rx)
		begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_cnt_r <= '0;
		end
		else
		begin
			if (rx_push && rx_cnt_r < cap)
				rx_wp_r <= rx_wp_r + 1'b1;
			if (rx_pop)
				rx_rp_r <= rx_rp_r + 1'b1;
			rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_push && rx_cnt_r < cap) - (AW+1)'(rx_pop);
		end
	end

	// line errors, set wins over the status read
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			oe_r <= 1'b0;
			fe_r <= 1'b0;
		end
		else
		begin
			if (rx_push && rx_cnt_r >= cap && !rx_pop)
				oe_r <= 1'b1;
			else if (rd_q && bus.addr == ADDR_LSR)
				oe_r <= 1'b0;
			if (rx_push && rx_fe)
				fe_r <= 1'b1;
			else if (rd_q && bus.addr == ADDR_LSR)
				fe_r <= 1'b0;
		end
	end

	// character timeout
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !fifo_en_r || rx_cnt_r == '0 || rx_push || rx_pop)
		begin
			to_cnt_r <= '0;
			to_ip_r <= 1'b0;
		end
		else if (tick && !to_ip_r)
		begin
			to_cnt_r <= to_cnt_r + 11'h001;
			if (to_cnt_r == TIMEOUT_TICKS + TO_EXTRA_TICKS - 11'h001)
				to_ip_r <= 1'b1;
		end
	end

	// modem status deltas
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			mprev_r <= PIN_IDLE[4:1];
			dlt_r <= '0;
		end
		else
		begin
			mprev_r <= filt_r[4:1];
			if (rd_q && bus.addr == ADDR_MSR)
				dlt_r <= '0;
			dlt_r[0] <= (mprev_r[0] ^ filt_r.cts_n) | (dlt_r[0] & !(rd_q && bus.addr == ADDR_MSR));
			dlt_r[1] <= (mprev_r[1] ^ filt_r.dsr_n) | (dlt_r[1] & !(rd_q && bus.addr == ADDR_MSR));
			dlt_r[2] <= (!mprev_r[2] & filt_r.ri_n) | (dlt_r[2] & !(rd_q && bus.addr == ADDR_MSR));
			dlt_r[3] <= (mprev_r[3] ^ filt_r.dcd_n) | (dlt_r[3] & !(rd_q && bus.addr == ADDR_MSR));
		end
	end

	// interrupt priority
	assign ls_pend = ier_r[IER_LS_BIT] & (oe_r | fe_r);
	assign rda_pend = ier_r[IER_RDA_BIT] & (fifo_en_r ? rx_cnt_r >= trig : rx_cnt_r != '0);
	always_comb
	begin
		if (ls_pend)
			iid = IID_LS;
		else if (rda_pend)
			iid = IID_RDA;
		else if (ier_r[IER_RDA_BIT] && to_ip_r)
			iid = IID_TO;
		else if (ier_r[IER_HOLDING_EMPTY_FLAG_BIT] && holding_empty_flag_ip_r)
			iid = IID_HOLDING_EMPTY_FLAG;
		else if (ier_r[IER_MS_BIT] && dlt_r != '0)
			iid = IID_MS;
		else
			iid = IID_NONE;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			host_interrupt_out <= 1'b0;
		else
			host_interrupt_out <= iid != IID_NONE;
	end

	// dma requests
	assign receive_dma_request_n = mode1 ? !(rx_cnt_r >= trig || to_ip_r) : rx_cnt_r == '0;
	assign transmit_dma_request_n = mode1 ? tx_cnt_r >= cap : tx_cnt_r != '0;

	// read data
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
		end
		else
		begin
			data_oe_n <= !rd_q;
			if (rd_q)
			begin
				case (bus.addr)
					ADDR_DATA: data_out <= divisor_access_select ? div_r[7:0] : rx_mem[rx_rp_r][7:0];
					ADDR_IER: data_out <= divisor_access_select ? div_r[15:8] : ier_r;
					ADDR_IIR: data_out <= {fifo_en_r, fifo_en_r, 2'b00, iid};
					ADDR_LCR: data_out <= lcr_r;
					ADDR_MCR: data_out <= {3'b000, mcr_r};
					ADDR_LSR: data_out <= {1'b0, temt_r, tx_cnt_r == '0, 1'b0, fe_r, 1'b0, oe_r, rx_cnt_r != '0};
					ADDR_MSR: data_out <= {~filt_r[4:1], dlt_r};
					default: data_out <= scr_r;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: design/uart_pkg.sv
package uart_pkg;
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_IIR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [2:0] ADDR_SCR = 3'h7;
	localparam int DIVISOR_ACCESS_SELECT_BIT = 7;
	localparam int FCR_EN_BIT = 0;
	localparam int FCR_RXRST_BIT = 1;
	localparam int FCR_TXRST_BIT = 2;
	localparam int FCR_DMA_BIT = 3;
	localparam int IER_RDA_BIT = 0;
	localparam int IER_HOLDING_EMPTY_FLAG_BIT = 1;
	localparam int IER_LS_BIT = 2;
	localparam int IER_MS_BIT = 3;
	localparam logic [7:0] LSR_RESET = 8'h60;
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_LS = 4'h6;
	localparam logic [3:0] IID_RDA = 4'h4;
	localparam logic [3:0] IID_TO = 4'hC;
	localparam logic [3:0] IID_HOLDING_EMPTY_FLAG = 4'h2;
	localparam logic [3:0] IID_MS = 4'h0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [4:0] PIN_IDLE = 5'h1F;
	localparam logic [3:0] TICKS_PER_BIT = 4'hF;
	localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
	localparam logic [4:0] TX_START_TICKS = 5'h10;
	localparam logic [3:0] TEMT_TICKS = 4'h8;
	localparam logic [10:0] TIMEOUT_TICKS = 11'h280;
	localparam logic [10:0] TO_EXTRA_TICKS = 11'h008;
	localparam logic [4:0] TRIG_00 = 5'h01;
	localparam logic [4:0] TRIG_01 = 5'h04;
	localparam logic [4:0] TRIG_10 = 5'h08;
	localparam logic [4:0] TRIG_11 = 5'h0E;
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} bus_req_t;
	typedef struct packed {
		logic dcd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
		logic sin;
	} pins_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SHIFT = 2'b10,
		TX_STOP = 2'b11
	} tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;
endpackage

// file: tb/uart_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module uart_core_sva
	import uart_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// host bus
	input wire bus_req_t bus,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	// pins and requests
	input wire pins_t pins,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic user_output_one_n,
	input wire logic user_output_two_n,
	input wire logic host_interrupt_out,
	input wire logic transmit_dma_request_n
);
	logic [7:0] lcr_r, scr_r, ier_r, dll_r, dlh_r, fcr_r;
	logic wr, rd, thr_wr;
	assign wr = bus.cs && bus.wr;
	assign rd = bus.cs && bus.rd;
	assign thr_wr = wr && bus.addr == ADDR_DATA && !lcr_r[DIVISOR_ACCESS_SELECT_BIT];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// shadow copies of the host-written registers except the modem control register
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			lcr_r <= REG_RESET;
			scr_r <= REG_RESET;
			ier_r <= REG_RESET;
			fcr_r <= REG_RESET;
			{dlh_r, dll_r} <= DIV_RESET;
		end
		else if (wr)
		begin
			if (bus.addr == ADDR_LCR) lcr_r <= bus.wdata;
			if (bus.addr == ADDR_SCR) scr_r <= bus.wdata;
			if (bus.addr == ADDR_IIR) fcr_r <= bus.wdata;
			if (bus.addr == ADDR_DATA && lcr_r[DIVISOR_ACCESS_SELECT_BIT]) dll_r <= bus.wdata;
			if (bus.addr == ADDR_IER && lcr_r[DIVISOR_ACCESS_SELECT_BIT]) dlh_r <= bus.wdata;
			if (bus.addr == ADDR_IER && !lcr_r[DIVISOR_ACCESS_SELECT_BIT]) ier_r <= {4'h0, bus.wdata[3:0]};
		end
	end
	a_read_drives_bus: assert property (data_oe_n == !$past(rd))
		else $error("bus drive enable wrong");
	a_scratch_read_back: assert property (rd && bus.addr == ADDR_SCR |=> data_out == $past(scr_r))
		else $error("scratch read wrong");
	a_ier_read_back: assert property (rd && !lcr_r[DIVISOR_ACCESS_SELECT_BIT] && bus.addr == ADDR_IER |=>
		data_out == $past(ier_r))
		else $error("interrupt enable read wrong");
	a_lcr_read_back: assert property (rd && bus.addr == ADDR_LCR |=> data_out == $past(lcr_r))
		else $error("line control read wrong");
	a_divisor_read_back: assert property (rd && lcr_r[DIVISOR_ACCESS_SELECT_BIT] && bus.addr[2:1] == 2'b00 |=>
		data_out == ($past(bus.addr[0]) ? $past(dlh_r) : $past(dll_r)))
		else $error("divisor read wrong");
	a_mcr_drives_pins: assert property (wr && bus.addr == ADDR_MCR |=>
		{user_output_two_n, user_output_one_n, rts_n, dtr_n} == ~$past(bus.wdata[3:0]))
		else $error("modem outputs wrong");
	a_holding_write_txreq: assert property (thr_wr && !(fcr_r[FCR_EN_BIT] && fcr_r[FCR_DMA_BIT]) |=>
		transmit_dma_request_n)
		else $error("transmit request not released");
	a_holding_write_clears: assert property (thr_wr && ier_r == 8'h02 |-> ##2 !host_interrupt_out)
		else $error("holding empty interrupt not cleared");
	a_modem_change_irq: assert property ($changed(pins.cts_n) && ier_r[IER_MS_BIT] |->
		##[1:8] host_interrupt_out)
		else $error("modem interrupt missing");
	c_holding_write: cover property (thr_wr);
	c_modem_read: cover property (rd && bus.addr == ADDR_MSR);
	c_divisor_read: cover property (rd && lcr_r[DIVISOR_ACCESS_SELECT_BIT] && bus.addr == ADDR_DATA);
endmodule
bind uart_core uart_core_sva uart_core_sva_inst (.mclk, .rst_n, .bus, .data_out, .data_oe_n, .pins, .rts_n,
	.dtr_n, .user_output_one_n, .user_output_two_n, .host_interrupt_out, .transmit_dma_request_n);
`default_nettype wire

// file: tb/line_peer.sv
`timescale 1ns/100ps
`default_nettype none
module line_peer
	import uart_pkg::*;
(
	// clock
	input wire logic mclk,
	// serial and modem lines
	output var pins_t pins,
	input wire logic serial_output
);
	// sixteen ticks a bit at divisor one
	localparam int BIT_CYCLES = 16;
	initial pins = PIN_IDLE;
	// start bit, eight data bits lsb first, one stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			pins.sin <= frame[i];
			repeat (BIT_CYCLES) @(posedge mclk);
		end
	endtask
	// samples each data bit in its middle
	task automatic get_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (serial_output !== 1'b0 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		ok = n < 400;
		repeat (BIT_CYCLES * 3 / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = serial_output;
			repeat (BIT_CYCLES) @(posedge mclk);
		end
	endtask
	// {carrier, ring, set ready, clear to send}, active low
	task automatic set_modem(input logic [3:0] v);
		pins[4:1] <= v;
	endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
	import uart_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	bus_req_t bus = '0;
	logic [7:0] data_out, b, v, got;
	logic data_oe_n, serial_output, rts_n, dtr_n, user_output_one_n, user_output_two_n, ok;
	logic host_interrupt_out, transmit_dma_request_n, receive_dma_request_n;
	pins_t pins;
	int mismatches = 0;
	int checks = 0;
	int n, k;
	time t0;
	logic [7:0] exp_q[$];
	always #2.5 mclk = ~mclk;
	uart_core uart_core_inst (.mclk, .rst_n, .bus, .data_out, .data_oe_n, .pins, .serial_output, .rts_n,
		.dtr_n, .user_output_one_n, .user_output_two_n, .host_interrupt_out, .transmit_dma_request_n,
		.receive_dma_request_n);
	line_peer line_peer_inst (.mclk, .pins, .serial_output);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		bus <= '{cs: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk);
		bus <= '0;
		@(posedge mclk);
	endtask
	// expected read data goes to the queue, the watcher compares it
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		bus <= '{cs: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge mclk);
		bus <= '0;
		@(posedge mclk);
	endtask
	task automatic wait_irq(input logic lvl, output int c);
		c = 0;
		while (host_interrupt_out !== lvl && c < 400)
		begin
			@(posedge mclk);
			c++;
		end
	endtask
	task automatic final_report();
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge mclk)
		if (data_oe_n === 1'b0)
			check(data_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
	initial
	begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		final_report();
	end
	initial
	begin
		v = 8'($urandom(32'h553A));
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd_reg(ADDR_LSR, LSR_RESET);
		rd_reg(ADDR_IIR, 8'h01);
		v = 8'($urandom());
		wr_reg(ADDR_SCR, v);
		rd_reg(ADDR_SCR, v);
		wr_reg(ADDR_LCR, 8'h83);
		wr_reg(ADDR_DATA, 8'h01);
		wr_reg(ADDR_IER, v);
		rd_reg(ADDR_DATA, 8'h01);
		rd_reg(ADDR_IER, v);
		rd_reg(ADDR_IIR, 8'h01);
		wr_reg(ADDR_IER, 8'h00);
		wr_reg(ADDR_LCR, 8'h03);
		rd_reg(ADDR_LCR, 8'h03);
		v = 8'($urandom()) & 8'h0F;
		wr_reg(ADDR_MCR, v);
		check({4'h0, user_output_two_n, user_output_one_n, rts_n, dtr_n}, ~v & 8'h0F);
		// transmit one byte and time its events
		wr_reg(ADDR_IER, 8'h02);
		rd_reg(ADDR_IER, 8'h02);
		b = 8'($urandom());
		fork
			line_peer_inst.get_byte(got, ok);
		join_none
		wr_reg(ADDR_DATA, b);
		check({7'h0, transmit_dma_request_n}, 8'h01);
		n = 1;
		while (serial_output !== 1'b0 && n < 100)
		begin
			@(posedge mclk);
			n++;
		end
		t0 = $time;
		check(8'(n >= 9 && n <= 25), 8'h01);
		wait_irq(1'b1, k);
		check(8'(n + k >= 17 && n + k <= 33), 8'h01);
		check({7'h0, transmit_dma_request_n}, 8'h00);
		rd_reg(ADDR_IIR, {4'h0, IID_HOLDING_EMPTY_FLAG});
		@(posedge mclk);
		check({7'h0, host_interrupt_out}, 8'h00);
		wait_irq(1'b1, k);
		k = int'(($time - t0) / 5);
		check(8'(k >= 152 && k <= 153), 8'h01);
		check(got, b);
		check({7'h0, ok}, 8'h01);
		rd_reg(ADDR_LSR, LSR_RESET);
		// receive one byte
		wr_reg(ADDR_IER, 8'h01);
		b = 8'($urandom());
		line_peer_inst.send_byte(b);
		check({6'h0, host_interrupt_out, receive_dma_request_n}, 8'h02);
		rd_reg(ADDR_LSR, 8'h61);
		rd_reg(ADDR_DATA, b);
		@(posedge mclk);
		check({7'h0, host_interrupt_out}, 8'h00);
		// clear-to-send change
		wr_reg(ADDR_IER, 8'h08);
		line_peer_inst.set_modem(4'hE);
		wait_irq(1'b1, k);
		check(8'(k < 10), 8'h01);
		rd_reg(ADDR_MSR, 8'h11);
		@(posedge mclk);
		check({7'h0, host_interrupt_out}, 8'h00);
		// fifo receive below a trigger of four, then character timeout
		wr_reg(ADDR_IER, 8'h01);
		wr_reg(ADDR_IIR, 8'h49);
		b = 8'($urandom());
		line_peer_inst.send_byte(b);
		rd_reg(ADDR_LSR, 8'h61);
		check({7'h0, receive_dma_request_n}, 8'h01);
		repeat (640) @(posedge mclk);
		wait_irq(1'b1, k);
		check(8'(k >= 4 && k <= 6), 8'h01);
		check({7'h0, receive_dma_request_n}, 8'h00);
		rd_reg(ADDR_IIR, {2'b11, 2'b00, IID_TO});
		rd_reg(ADDR_DATA, b);
		repeat (85) @(posedge mclk);
		check({7'h0, host_interrupt_out}, 8'h00);
		rd_reg(ADDR_LSR, LSR_RESET);
		// request mode 1 then mode 0 with one byte queued
		wr_reg(ADDR_IER, 8'h00);
		wr_reg(ADDR_IIR, 8'h09);
		wr_reg(ADDR_DATA, b);
		check({7'h0, transmit_dma_request_n}, 8'h00);
		wr_reg(ADDR_IIR, 8'h01);
		check({7'h0, transmit_dma_request_n}, 8'h01);
		// holding-empty pending on the host output, cleared by a holding write
		wr_reg(ADDR_IER, 8'h02);
		wait_irq(1'b1, k);
		check(8'(k < 40), 8'h01);
		wr_reg(ADDR_DATA, b);
		@(posedge mclk);
		check({7'h0, host_interrupt_out}, 8'h00);
		repeat (200) @(posedge mclk);
		final_report();
	end
endmodule
`default_nettype wire
